// file: eeprom_array.v
/*
 * Byte-wide memory array of the EEPROM with registered read data.
 * Assumes a single clock; write and read addresses share one port.
 */
`timescale 1ns/1ps

module eeprom_array #(
	parameter ADDR_W = 11
) (
	input  wire              clock_i,
	input  wire              we_i,
	input  wire [ADDR_W-1:0] addr_i,
	input  wire [7:0]        wdata_i,
	output reg  [7:0]        rdata_o
);

	reg [7:0] mem_reg [0:(1<<ADDR_W)-1];

	always @(posedge clock_i)
	begin
		if (we_i)
			mem_reg[addr_i] <= wdata_i;
		rdata_o <= mem_reg[addr_i];
	end

endmodule // eeprom_array

// file: eeprom_consts.vh
/*
 * Constants for the serial EEPROM slave: select byte layout, bit counts,
 * page size and programming time. Included by the design files by bare name.
 */
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

`define DEV_TYPE_CODE      4'h5 // arbitrary type code of our own making
`define SEL_TYPE_MSB       7
`define SEL_TYPE_LSB       4
`define SEL_RW_BIT         0
`define BITS_PER_BYTE      4'h8
`define ACK_SLOT           4'h8
`define PAGE_BITS          4
`define PAGE_BYTES         16
`define PROG_TIME_NS       5000000
`define CLK_PERIOD_NS      8
`define ADDR_BITS_DEFAULT  11
`define SYNC_RESET_VAL     2'h3

`endif

// file: eeprom_slave_monitor.sv
/* checker of the eeprom slave pins: drive timing, programming cycle.
   assumes bind to serial_eeprom_i2c_slave, sda_i being the resolved wire */
`timescale 1ns/1ps
module eeprom_slave_monitor #(
	parameter ADDR_W     = 11,
	parameter PROG_COUNT = 625000
) (
	input logic clock_i,
	input logic rst_i,
	input logic scl_i,
	input logic sda_i,
	input logic chip_select_pin0_i,
	input logic chip_select_pin1_i,
	input logic chip_select_pin2_i,
	input logic write_protect_input_i,
	input logic sda_oe_o,
	input logic busy_o
);
	logic [31:0] bcnt_reg;
	logic [4:0]  stop_age_reg;
	logic        sda_last_reg;
	always @(posedge clock_i)
	begin
		sda_last_reg <= sda_i;
		bcnt_reg <= (rst_i | !busy_o) ? 32'h0 : bcnt_reg + 32'h1;
		if (rst_i)
			stop_age_reg <= 5'h1f;
		else if (scl_i & sda_i & !sda_last_reg)
			stop_age_reg <= 5'h0;
		else if (stop_age_reg != 5'h1f)
			stop_age_reg <= stop_age_reg + 5'h1;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// the pad may only move in the low phase, a few clocks after scl falls
	property p_oe_after_fall; $changed(sda_oe_o) |-> $past(scl_i, 6) && !$past(scl_i, 2); endproperty
	a_oe_after_fall: assert property (p_oe_after_fall) else $error("sda drive moved off scl low");
	property p_ack_len; $rose(sda_oe_o) |-> sda_oe_o [*8]; endproperty
	a_ack_len: assert property (p_ack_len) else $error("sda low pulse too short");
	property p_busy_quiet; busy_o |-> !sda_oe_o; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("sda driven while busy");
	property p_busy_len;
		$fell(busy_o) |-> bcnt_reg >= PROG_COUNT && bcnt_reg <= PROG_COUNT + 17;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("programming time off");
	property p_busy_min; $rose(busy_o) |-> busy_o [*8]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy dropped early");
	property p_busy_after_stop; $rose(busy_o) |-> stop_age_reg < 5'hc; endproperty
	a_busy_after_stop: assert property (p_busy_after_stop) else $error("busy without stop");
	property p_stop_idle; scl_i && $rose(sda_i) |-> !sda_oe_o [*8]; endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("sda driven after stop");
	property p_start_idle; scl_i && $fell(sda_i) |-> !sda_oe_o [*8]; endproperty
	a_start_idle: assert property (p_start_idle) else $error("sda driven at start");
	c_busy: cover property ($rose(busy_o));
	c_ack: cover property ($rose(sda_oe_o));
	c_done: cover property ($fell(busy_o));
endmodule // eeprom_slave_monitor
bind serial_eeprom_i2c_slave eeprom_slave_monitor #(.ADDR_W(ADDR_W), .PROG_COUNT(PROG_COUNT)) mon (
	.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
	.chip_select_pin0_i(chip_select_pin0_i), .chip_select_pin1_i(chip_select_pin1_i),
	.chip_select_pin2_i(chip_select_pin2_i), .write_protect_input_i(write_protect_input_i),
	.sda_oe_o(sda_oe_o), .busy_o(busy_o));

// file: i2c_master_model.sv
/* bus master model: start, stop and nine-bit transfers at 80 ns scl.
   assumes clock_i is the 8 ns bench clock; sda has a pull-up */
`timescale 1ns/1ps
module i2c_master_model (
	input  wire clock_i,
	input  wire sda_oe_i,
	output reg  scl_o,
	output wire sda_o
);
	reg sda_m_reg;
	initial
	begin
		scl_o = 1'b1;
		sda_m_reg = 1'b1;
	end
	// released line floats to the pull-up level
	assign sda_o = sda_m_reg & ~sda_oe_i;
	task cyc(input integer n);
		repeat (n) @(negedge clock_i);
	endtask
	task bit_io(input b, output r);
	begin
		cyc(3);
		sda_m_reg = b;
		cyc(2);
		scl_o = 1'b1;
		cyc(4);
		r = sda_o;
		cyc(1);
		scl_o = 1'b0;
	end
	endtask
	task start;
	begin
		cyc(3);
		sda_m_reg = 1'b1;
		cyc(2);
		scl_o = 1'b1;
		cyc(5);
		sda_m_reg = 1'b0;
		cyc(5);
		scl_o = 1'b0;
	end
	endtask
	task stop;
	begin
		cyc(3);
		sda_m_reg = 1'b0;
		cyc(2);
		scl_o = 1'b1;
		cyc(5);
		sda_m_reg = 1'b1;
		cyc(5);
	end
	endtask
	task xfer(input [7:0] d, input mack, output [7:0] q, output k);
		integer i;
	begin
		for (i = 7; i >= 0; i = i - 1)
			bit_io(d[i], q[i]);
		bit_io(mack, k);
	end
	endtask
endmodule // i2c_master_model

// file: serial_eeprom_i2c_slave.v
/*
 * Two-wire serial EEPROM slave: select decode, byte/page write with
 * self-timed programming, ack polling, current, random and sequential read.
 * Assumes scl_i, sda_i and write_protect_input_i are asynchronous pins;
 * sda is open drain, the pad driving low while sda_oe_o is high.
 */
// How it works
// - data bits taken on scl rising edge
// - upper four bits must match type code
// - used chip-select bits must match pins
// - eighth bit one reads, zero writes
// - ack on match, else release and standby
// - large arrays reuse chip-select bits as address
// - write: ack select, address loads counter
// - programming starts only on stop after data ack
// - busy programming ignores bus, acks nothing
// - protect during select/address nacks all data
// - page write takes one to sixteen bytes
// - write increments only low four address bits
// - busy device withholds select ack for polling
// - reads ignore write protect
// - random read: dummy write then read select
// - current read sends byte then increments
// - master ack continues with next address
// - read counter wraps to address zero
// - start and stop detected while scl high
// - no ack after read byte means standby
// - unconnected protect input reads low (no pull-down here: write_protect_input_i is sampled as driven)
`timescale 1ns/1ps
`include "eeprom_consts.vh"

module serial_eeprom_i2c_slave #(
	parameter ADDR_W     = `ADDR_BITS_DEFAULT,
	parameter PROG_TIME  = `PROG_TIME_NS,
	parameter CLK_NS     = `CLK_PERIOD_NS,
	parameter PROG_COUNT = PROG_TIME / CLK_NS
) (
	input  wire       clock_i,
	input  wire       rst_i,
	input  wire       scl_i,
	input  wire       sda_i,
	input  wire       chip_select_pin0_i,
	input  wire       chip_select_pin1_i,
	input  wire       chip_select_pin2_i,
	input  wire       write_protect_input_i,
	output reg        sda_oe_o,
	output reg        busy_o
);

	localparam ST_IDLE  = 3'h0;
	localparam ST_SEL   = 3'h1;
	localparam ST_ADDR  = 3'h2;
	localparam ST_WDATA = 3'h3;
	localparam ST_RDATA = 3'h4;
	localparam ST_PROG  = 3'h5;

	// how many chip-select bits become address bits above bit 7
	localparam HI_BITS = (ADDR_W > 8) ? ADDR_W - 8 : 0;
	localparam [31:0] PROG_CYC = (PROG_COUNT < 1) ? 1 : PROG_COUNT;

	function sel_match;
		input [7:0] sel;
		input [2:0] pins;
		integer k;
		begin
			sel_match = (sel[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == `DEV_TYPE_CODE);
			for (k = 0; k < 3; k = k + 1)
				if (k >= HI_BITS && sel[k+1] != pins[k])
					sel_match = 1'b0;
		end
	endfunction

	// two-flop synchronisers; the first stage feeds only the second
	reg [1:0] scl_sync_reg;
	reg [1:0] sda_sync_reg;
	reg [1:0] wp_sync_reg;
	reg [5:0] cs_sync_reg;
	reg       scl_d_reg;
	reg       sda_d_reg;

	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			scl_sync_reg <= `SYNC_RESET_VAL;
			sda_sync_reg <= `SYNC_RESET_VAL;
			wp_sync_reg  <= 2'h0;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			wp_sync_reg  <= {wp_sync_reg[0], write_protect_input_i};
			cs_sync_reg  <= {cs_sync_reg[2:0], chip_select_pin2_i,
				chip_select_pin1_i, chip_select_pin0_i};
			scl_d_reg    <= scl_sync_reg[1];
			sda_d_reg    <= sda_sync_reg[1];
		end
	end

	wire scl_s   = scl_sync_reg[1];
	wire sda_s   = sda_sync_reg[1];
	wire scl_pos = scl_s & ~scl_d_reg;
	wire scl_neg = ~scl_s & scl_d_reg;
	// scl must already be high for a clean start/stop
	wire start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_c  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	reg [2:0]        state_reg;
	reg [2:0]        state_next;
	reg [3:0]        bit_reg;
	reg [3:0]        bit_next;
	reg [7:0]        shift_reg;
	reg [7:0]        shift_next;
	reg [ADDR_W-1:0] addr_reg;
	reg [ADDR_W-1:0] addr_next;
	reg              ack_reg;
	reg              ack_next;
	reg              wp_seen_reg;
	reg              wp_seen_next;
	reg              armed_reg;
	reg              armed_next;
	reg              load_reg;
	reg              load_next;
	reg [31:0]       prog_cnt_reg;
	reg [31:0]       prog_cnt_next;
	reg              sda_oe_next;

	// page latches: data buffered until stop, then committed
	reg [7:0]        page_data_reg [0:`PAGE_BYTES-1];
	reg [`PAGE_BYTES-1:0] page_vld_reg;
	reg [`PAGE_BITS:0] commit_reg;
	wire             mem_we;
	wire [ADDR_W-1:0] mem_addr;
	wire [7:0]       mem_rdata;

	wire             in_byte  = (bit_reg < `BITS_PER_BYTE);
	wire             in_ack   = (bit_reg == `ACK_SLOT);
	wire             wp_now   = wp_seen_reg | wp_sync_reg[1];
	wire             committing = (state_reg == ST_PROG) && !commit_reg[`PAGE_BITS];
	wire [`PAGE_BITS-1:0] commit_idx = commit_reg[`PAGE_BITS-1:0];

	eeprom_array #(
		.ADDR_W (ADDR_W)
	) u_array (
		.clock_i (clock_i),
		.we_i    (mem_we),
		.addr_i  (mem_addr),
		.wdata_i (page_data_reg[commit_idx]),
		.rdata_o (mem_rdata)
	);

	assign mem_we   = committing && page_vld_reg[commit_idx] && !wp_seen_reg;
	assign mem_addr = committing
		? {addr_reg[ADDR_W-1:`PAGE_BITS], commit_idx} : addr_reg;

	always @*
	begin
		state_next    = state_reg;
		bit_next      = bit_reg;
		shift_next    = shift_reg;
		addr_next     = addr_reg;
		ack_next      = ack_reg;
		wp_seen_next  = wp_seen_reg;
		armed_next    = armed_reg;
		load_next     = 1'b0;
		prog_cnt_next = prog_cnt_reg;
		sda_oe_next   = sda_oe_o;
		if (state_reg == ST_PROG)
		begin
			sda_oe_next = 1'b0;
			if (commit_reg[`PAGE_BITS])
			begin
				if (prog_cnt_reg >= PROG_CYC - 1)
					state_next = ST_IDLE;
				else
					prog_cnt_next = prog_cnt_reg + 32'h1;
			end
		end
		else if (start_c)
		begin
			state_next   = ST_SEL;
			bit_next     = 4'h0;
			sda_oe_next  = 1'b0;
			wp_seen_next = wp_sync_reg[1];
			armed_next   = 1'b0;
		end
		else if (stop_c)
		begin
			sda_oe_next = 1'b0;
			// stop in the slot after a data ack; its scl rise counts one bit
			if (state_reg == ST_WDATA && armed_reg && bit_reg[3:1] == 3'h0)
				state_next = ST_PROG;
			else
				state_next = ST_IDLE;
			prog_cnt_next = 32'h0;
		end
		else if (state_reg != ST_IDLE)
		begin
			if (state_reg != ST_RDATA && state_reg != ST_WDATA)
				wp_seen_next = wp_now;
			if (scl_pos && in_byte && state_reg != ST_RDATA)
				shift_next = {shift_reg[6:0], sda_s};
			if (scl_pos && (in_byte || in_ack))
				bit_next = bit_reg + 4'h1;
			if (scl_pos && in_ack && state_reg == ST_RDATA)
				ack_next = ~sda_s;
			if (scl_neg && bit_reg == `BITS_PER_BYTE)
			begin
				case (state_reg)
				ST_SEL:
				begin
					if (sel_match(shift_reg, cs_sync_reg[5:3]))
					begin
						sda_oe_next = 1'b1;
						if (HI_BITS > 0)
							addr_next = set_hi(addr_reg, shift_reg[3:1]);
					end
					else
						state_next = ST_IDLE;
				end
				ST_ADDR:
				begin
					sda_oe_next = 1'b1;
					addr_next = set_lo(addr_reg, shift_reg);
				end
				ST_WDATA:
				begin
					sda_oe_next = ~wp_seen_reg;
					armed_next  = ~wp_seen_reg;
				end
				ST_RDATA:
					sda_oe_next = 1'b0;
				default:
					state_next = ST_IDLE;
				endcase
			end
			else if (scl_neg && bit_reg == 4'h9)
			begin
				load_next   = (state_reg == ST_SEL) && shift_reg[`SEL_RW_BIT];
				bit_next    = 4'h0;
				sda_oe_next = 1'b0;
				case (state_reg)
				ST_SEL:
					state_next = shift_reg[`SEL_RW_BIT] ? ST_RDATA : ST_ADDR;
				ST_ADDR:
					state_next = ST_WDATA;
				ST_WDATA:
					// page-local increment wraps inside the page
					addr_next = {addr_reg[ADDR_W-1:`PAGE_BITS],
						addr_reg[`PAGE_BITS-1:0] + 1'b1};
				ST_RDATA:
					if (ack_reg)
						load_next = 1'b1;
					else
						state_next = ST_IDLE;
				default:
					state_next = ST_IDLE;
				endcase
			end
			else if (scl_neg && state_reg == ST_RDATA && in_byte)
			begin
				// shift out msb first; one bits release the line
				sda_oe_next = ~shift_reg[7];
				shift_next  = {shift_reg[6:0], 1'b1};
			end
		end
		if (load_reg)
		begin
			// array data ready: present first bit and step counter in the same cycle
			shift_next  = {mem_rdata[6:0], 1'b1};
			sda_oe_next = ~mem_rdata[7];
			addr_next   = addr_reg + 1'b1;
		end
	end

	function [ADDR_W-1:0] set_hi;
		input [ADDR_W-1:0] a;
		input [2:0]        h;
		integer j;
		begin
			set_hi = a;
			for (j = 8; j < ADDR_W; j = j + 1)
				set_hi[j] = h[j-8];
		end
	endfunction

	function [ADDR_W-1:0] set_lo;
		input [ADDR_W-1:0] a;
		input [7:0]        b;
		integer j;
		begin
			set_lo = a;
			for (j = 0; j < 8 && j < ADDR_W; j = j + 1)
				set_lo[j] = b[j];
		end
	endfunction

	// page latch capture at the ack decision of each data byte while wp_seen_reg is low
	integer i;
	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			page_vld_reg <= {`PAGE_BYTES{1'b0}};
			commit_reg   <= {(`PAGE_BITS+1){1'b1}};
			for (i = 0; i < `PAGE_BYTES; i = i + 1)
				page_data_reg[i] <= 8'h00;
		end
		else
		begin
			if (start_c && state_reg != ST_PROG)
				page_vld_reg <= {`PAGE_BYTES{1'b0}};
			else if (state_reg == ST_WDATA && scl_neg && bit_reg == `BITS_PER_BYTE
				&& !wp_seen_reg)
			begin
				page_data_reg[addr_reg[`PAGE_BITS-1:0]] <= shift_reg;
				page_vld_reg[addr_reg[`PAGE_BITS-1:0]]  <= 1'b1;
			end
			if (state_next == ST_PROG && state_reg != ST_PROG)
				commit_reg <= {(`PAGE_BITS+1){1'b0}};
			else if (committing)
				commit_reg <= commit_reg + 1'b1;
		end
	end

	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_reg    <= ST_IDLE;
			bit_reg      <= 4'h0;
			shift_reg    <= 8'h00;
			addr_reg     <= {ADDR_W{1'b0}};
			ack_reg      <= 1'b0;
			wp_seen_reg  <= 1'b0;
			armed_reg    <= 1'b0;
			load_reg     <= 1'b0;
			prog_cnt_reg <= 32'h0;
			sda_oe_o     <= 1'b0;
			busy_o       <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			bit_reg      <= bit_next;
			shift_reg    <= shift_next;
			addr_reg     <= addr_next;
			ack_reg      <= ack_next;
			wp_seen_reg  <= wp_seen_next;
			armed_reg    <= armed_next;
			load_reg     <= load_next;
			prog_cnt_reg <= prog_cnt_next;
			sda_oe_o     <= sda_oe_next;
			busy_o       <= (state_next == ST_PROG);
		end
	end

endmodule // serial_eeprom_i2c_slave

// file: serial_eeprom_i2c_slave_test.sv
/* self-checking bench for the eeprom slave with a 512-byte array.
   assumes the master model and the bound checker */
`timescale 1ns/1ps
`include "eeprom_consts.vh"
module serial_eeprom_i2c_slave_test;
	reg         clock_i;
	reg         rst_i;
	reg         wp;
	reg  [2:0]  pins;
	wire        scl;
	wire        sda;
	wire        oe;
	wire        busy;
	reg  [7:0]  mem [0:511];
	reg  [7:0]  q;
	reg         k;
	integer     errors;
	integer     checks;
	integer     cycles;
	// short programming time, still longer than one poll
	serial_eeprom_i2c_slave #(.ADDR_W(9), .PROG_COUNT(400)) DUT (.clock_i(clock_i),
		.rst_i(rst_i), .scl_i(scl), .sda_i(sda), .chip_select_pin0_i(pins[0]),
		.chip_select_pin1_i(pins[1]), .chip_select_pin2_i(pins[2]),
		.write_protect_input_i(wp), .sda_oe_o(oe), .busy_o(busy));
	i2c_master_model M (.clock_i(clock_i), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));
	function [7:0] sel(input a8, input rw);
		sel = {`DEV_TYPE_CODE, pins[2:1], a8, rw};
	endfunction
	task chk(input string nm, input [7:0] s, input [7:0] e);
	begin
		checks = checks + 1;
		if (s !== e)
		begin
			errors = errors + 1;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	end
	endtask
	task wrap_up;
	begin
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	task wr(input [8:0] a, input integer n, input [7:0] d, input nk);
		integer i;
	begin
		M.start;
		M.xfer(sel(a[8], 1'b0), 1'b1, q, k);
		chk("sel ack", 8'(k), 8'h0);
		M.xfer(a[7:0], 1'b1, q, k);
		chk("addr ack", 8'(k), 8'h0);
		for (i = 0; i < n; i = i + 1)
		begin
			M.xfer(d + i[7:0], 1'b1, q, k);
			chk("data ack", 8'(k), 8'(nk));
			if (!nk)
				mem[{a[8:4], a[3:0] + i[3:0]}] = d + i[7:0];
		end
		M.stop;
		M.cyc(8);
		chk("busy", 8'(busy), 8'(!nk));
		M.start;
		M.xfer(sel(1'b0, 1'b0), 1'b1, q, k);
		chk("poll", 8'(k), 8'(!nk));
		for (i = 0; i < 9 && k; i = i + 1)
		begin
			M.stop;
			M.start;
			M.xfer(sel(1'b0, 1'b0), 1'b1, q, k);
		end
		chk("poll end", 8'(k), 8'h0);
		M.stop;
	end
	endtask
	task rd(input [8:0] a, input integer n);
		integer i;
	begin
		M.start;
		M.xfer(sel(a[8], 1'b0), 1'b1, q, k);
		M.xfer(a[7:0], 1'b1, q, k);
		M.start;
		M.xfer(sel(a[8], 1'b1), 1'b1, q, k);
		chk("rd sel", 8'(k), 8'h0);
		for (i = 0; i < n; i = i + 1)
		begin
			M.xfer(8'hff, i == n - 1, q, k);
			chk("rd data", q, mem[a + i[8:0]]);
		end
		M.stop;
	end
	endtask
	task t_page;
	begin
		wr(9'h1f0, 16, 8'h40, 1'b0);
		wr(9'h000, 2, 8'ha0, 1'b0);
		wr(9'h0fe, 3, 8'h70, 1'b0);
		rd(9'h1fe, 4);
		rd(9'h0f0, 1);
		$display("page write and read wrap done");
	end
	endtask
	task t_protect;
	begin
		wp = 1'b1;
		wr(9'h000, 1, 8'hee, 1'b1);
		rd(9'h000, 1);
		M.start;
		M.xfer(sel(1'b0, 1'b1), 1'b1, q, k);
		chk("cur ack", 8'(k), 8'h0);
		M.xfer(8'hff, 1'b1, q, k);
		chk("cur data", q, mem[1]);
		M.stop;
		wp = 1'b0;
		$display("protect and current read done");
	end
	endtask
	task t_refuse;
	begin
		M.start;
		M.xfer(sel(1'b0, 1'b0) ^ 8'h10, 1'b1, q, k);
		chk("type nack", 8'(k), 8'h1);
		M.stop;
		M.start;
		M.xfer(sel(1'b0, 1'b0) ^ 8'h04, 1'b1, q, k);
		chk("pin nack", 8'(k), 8'h1);
		M.stop;
		M.start;
		M.xfer(sel(1'b0, 1'b0), 1'b1, q, k);
		M.xfer(8'h05, 1'b1, q, k);
		M.stop;
		M.cyc(8);
		chk("no prog", 8'(busy), 8'h0);
		$display("refusals done");
	end
	endtask
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	always @(posedge clock_i)
	begin
		cycles = cycles + 1;
		if (cycles == 40000)
		begin
			errors = errors + 1;
			wrap_up;
		end
	end
	initial
	begin
		rst_i = 1'b1;
		wp = 1'b0;
		pins = 3'b010;
		errors = 0;
		checks = 0;
		cycles = 0;
		repeat (8) @(posedge clock_i);
		@(negedge clock_i);
		rst_i = 1'b0;
		M.cyc(4);
		t_refuse;
		t_page;
		t_protect;
		wrap_up;
	end
endmodule // serial_eeprom_i2c_slave_test
